// ===== hw/array_pkg.sv
// constants shared by the 144-row datapath array and its storage
package array_pkg;
  localparam int unsigned ROWS            = 144;
  localparam int unsigned WIDTH           = 149;
  localparam int unsigned ADDR_W          = 8;
  localparam int unsigned DESIGN_FREQ_MHZ = 375;
  localparam int unsigned CLOCK_FREQ_MHZ  = 25;
  // capture chain layout, scan order from the top bit down to bit 0
  localparam int unsigned DIN_LSB         = 0;
  localparam int unsigned WADDR_LSB       = DIN_LSB + WIDTH;
  localparam int unsigned RADDR_LSB       = WADDR_LSB + ADDR_W;
  localparam int unsigned WREQ_BIT        = RADDR_LSB + ADDR_W;
  localparam int unsigned RREQ_BIT        = WREQ_BIT + 1;
  localparam int unsigned CHAIN_W         = RREQ_BIT + 1;
  // reset values
  localparam logic [CHAIN_W-1:0] CAPTURE_RESET = '0;
  localparam logic               INHIBIT_RESET = 1'b0;
  localparam logic [WIDTH-1:0]   READ_IDLE     = '1;
endpackage

// ===== hw/array_if.sv
// request and answer signals between the array control and its storage
interface array_if #(
  parameter int unsigned WIDTH  = array_pkg::WIDTH,
  parameter int unsigned ADDR_W = array_pkg::ADDR_W
);
  logic              rd_act;
  logic [ADDR_W-1:0] rd_addr;
  logic              hold;
  logic              wr_act;
  logic [ADDR_W-1:0] wr_addr;
  logic [WIDTH-1:0]  wr_data;
  logic [WIDTH-1:0]  rd_data;

  modport ctrl (
    output rd_act,
    output rd_addr,
    output hold,
    output wr_act,
    output wr_addr,
    output wr_data,
    input  rd_data
  );
  modport store (
    input  rd_act,
    input  rd_addr,
    input  hold,
    input  wr_act,
    input  wr_addr,
    input  wr_data,
    output rd_data
  );
endinterface

// ===== hw/array_store.sv
// storage rows with registered read data, read before write on one edge
module array_store #(
  parameter int unsigned ROWS  = array_pkg::ROWS,
  parameter int unsigned WIDTH = array_pkg::WIDTH
) (
  input  wire logic    i_clock,
  input  wire logic    i_rst,
  array_if.store       port
);
  logic [WIDTH-1:0] mem [ROWS];
  logic [WIDTH-1:0] rd_data_r;
  logic [WIDTH-1:0] rd_data_nxt;

  // a same-row write lands on this edge too, so the read sees the old row
  always_comb begin
    if (port.hold) begin
      rd_data_nxt = rd_data_r;
    end else if (port.rd_act) begin
      rd_data_nxt = mem[port.rd_addr];
    end else begin
      rd_data_nxt = array_pkg::READ_IDLE;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      rd_data_r <= array_pkg::READ_IDLE;
    end else begin
      rd_data_r <= rd_data_nxt;
    end
  end

  // rows carry no reset; a row reads unknown until it is first written
  always_ff @(posedge i_clock) begin
    if (port.wr_act) begin
      mem[port.wr_addr] <= port.wr_data;
    end
  end

  assign port.rd_data = rd_data_r;
endmodule // array_store

// ===== hw/datapath_array_cell.sv
// 144 x 149 one-read one-write datapath array with scannable input capture
//
// Contract
// RULE_01 - 144 rows of 149 bits, separate read and write ports, one clock.
// RULE_02 - all 149 write data bits captured in scannable flops on rising edge.
// RULE_03 - read data held stable in an output stage between reads; held only while frozen or inhibited, a cycle with no read gives all ones.
// RULE_04 - read and write row selects are 8 bits, captured in scannable flops.
// RULE_05 - separate read and write requests, each captured in a scannable flop.
// RULE_06 - read row captured on rising edge; decode qualified by captured read request.
// RULE_07 - a read completes within one cycle after capture.
// RULE_08 - output stage takes the read value in the same cycle as the read.
// RULE_09 - write row captured on rising edge; decode qualified by captured write request.
// RULE_10 - write data committed in the cycle after capture.
// RULE_11 - write only or no request, not inhibited: read output shows all ones.
// RULE_12 - read only, not inhibited: output the last data written to that row.
// RULE_13 - read and write to different rows in one cycle both complete.
// RULE_14 - requester never reads and writes the same row in one cycle; the bench requester does so when clash_ok is set.
// RULE_15 - same-row collision returns old content and stores the new data.
// RULE_16 - array designed for a 375 MHz core clock.
// RULE_17 - while inhibited, no reads or writes; read output undefined.
module datapath_array_cell #(
  parameter int unsigned ROWS   = array_pkg::ROWS,
  parameter int unsigned WIDTH  = array_pkg::WIDTH,
  parameter int unsigned ADDR_W = array_pkg::ADDR_W
) (
  input  wire logic              i_clock,
  input  wire logic              i_rst,
  input  wire logic              i_rd_en,
  input  wire logic [ADDR_W-1:0] i_rd_addr,
  input  wire logic              i_wr_en,
  input  wire logic [ADDR_W-1:0] i_wr_addr,
  input  wire logic [WIDTH-1:0]  i_wr_data,
  input  wire logic              i_array_inhibit,
  input  wire logic              i_clock_header_enable,
  input  wire logic              i_clock_header_override,
  input  wire logic              i_collar_shift_select,
  input  wire logic              i_scan_in,
  output      logic [WIDTH-1:0]  o_rd_data,
  output      logic              o_scan_out
);
  localparam int unsigned CHAIN_W = 2 + 2 * ADDR_W + WIDTH;
  // design target rate; this model runs at the system clock instead
  localparam int unsigned DESIGN_FREQ_MHZ = array_pkg::DESIGN_FREQ_MHZ; // RULE_16

  logic [CHAIN_W-1:0] cap_r;
  logic [CHAIN_W-1:0] cap_nxt;
  logic               inh_r;
  logic               inh_nxt;
  logic               run;
  logic               go;
  logic               rd_en_r;
  logic               wr_en_r;
  logic [ADDR_W-1:0]  rd_addr_r;
  logic [ADDR_W-1:0]  wr_addr_r;
  logic [WIDTH-1:0]   din_r;
  logic               rd_act;
  logic               wr_act;

  array_if #(.WIDTH(WIDTH), .ADDR_W(ADDR_W)) arr ();

  // gated clock header modelled as an enable; shift mode freezes the array
  assign run = i_clock_header_enable | i_clock_header_override;
  assign go  = run & ~i_collar_shift_select;

  // capture chain: parallel load in function, serial shift in scan
  always_comb begin
    if (i_collar_shift_select) begin
      cap_nxt = {cap_r[CHAIN_W-2:0], i_scan_in};
    end else if (run) begin
      cap_nxt = {i_rd_en, i_wr_en, i_rd_addr, i_wr_addr, i_wr_data}; // RULE_02 RULE_04 RULE_05
    end else begin
      cap_nxt = cap_r;
    end
    inh_nxt = go ? i_array_inhibit : inh_r;
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      cap_r <= array_pkg::CAPTURE_RESET;
      inh_r <= array_pkg::INHIBIT_RESET;
    end else begin
      cap_r <= cap_nxt; // RULE_06 RULE_09
      inh_r <= inh_nxt;
    end
  end

  assign rd_en_r   = cap_r[array_pkg::RREQ_BIT];
  assign wr_en_r   = cap_r[array_pkg::WREQ_BIT];
  assign rd_addr_r = cap_r[array_pkg::RADDR_LSB +: ADDR_W];
  assign wr_addr_r = cap_r[array_pkg::WADDR_LSB +: ADDR_W];
  assign din_r     = cap_r[array_pkg::DIN_LSB +: WIDTH];

  // rows at or above the depth are not decoded: writes drop, reads give ones
  assign rd_act = go & ~inh_r & rd_en_r & (rd_addr_r < ADDR_W'(ROWS)); // RULE_06 RULE_17
  assign wr_act = go & ~inh_r & wr_en_r & (wr_addr_r < ADDR_W'(ROWS)); // RULE_09 RULE_17

  // inhibit keeps the last output, one legal choice for an undefined value
  assign arr.rd_act  = rd_act; // RULE_07 RULE_08 RULE_12
  assign arr.rd_addr = rd_addr_r;
  assign arr.hold    = ~go | inh_r; // RULE_03 RULE_17
  assign arr.wr_act  = wr_act; // RULE_10 RULE_13
  assign arr.wr_addr = wr_addr_r;
  assign arr.wr_data = din_r;

  array_store #(
    .ROWS  (ROWS),
    .WIDTH (WIDTH)
  ) u_store (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .port    (arr.store)
  ); // RULE_01 RULE_11 RULE_15

  assign o_rd_data  = arr.rd_data;
  assign o_scan_out = cap_r[CHAIN_W-1];

  property p_idle_ones;
    @(posedge i_clock) disable iff (i_rst)
      (go && !inh_r && !rd_en_r) |=> (o_rd_data == {WIDTH{1'b1}});
  endproperty
  a_idle_ones: assert property (p_idle_ones) // RULE_11
    else $error("read output not all ones without a read");

  property p_read_back;
    @(posedge i_clock) disable iff (i_rst)
      (wr_act && !rd_act) ##1 (rd_act && !wr_act && rd_addr_r == $past(wr_addr_r))
      |=> (o_rd_data == $past(din_r, 2));
  endproperty
  a_read_back: assert property (p_read_back) // RULE_12
    else $error("read did not return last written row data");

  property p_both_ports;
    @(posedge i_clock) disable iff (i_rst)
      (wr_act && rd_act && rd_addr_r != wr_addr_r) ##1
      (rd_act && !wr_act && rd_addr_r == $past(wr_addr_r))
      |=> (o_rd_data == $past(din_r, 2));
  endproperty
  a_both_ports: assert property (p_both_ports) // RULE_13
    else $error("simultaneous write to another row was lost");

  property p_collision_store;
    @(posedge i_clock) disable iff (i_rst)
      (wr_act && rd_act && rd_addr_r == wr_addr_r) ##1
      (rd_act && !wr_act && rd_addr_r == $past(wr_addr_r))
      |=> (o_rd_data == $past(din_r, 2));
  endproperty
  a_collision_store: assert property (p_collision_store) // RULE_15
    else $error("collision write not stored");

  property p_inhibit_hold;
    @(posedge i_clock) disable iff (i_rst)
      (go && inh_r) |=> $stable(o_rd_data);
  endproperty
  a_inhibit_hold: assert property (p_inhibit_hold) // RULE_17
    else $error("read output moved while inhibited");

  property p_frozen_hold;
    @(posedge i_clock) disable iff (i_rst)
      !go |=> $stable(o_rd_data);
  endproperty
  a_frozen_hold: assert property (p_frozen_hold) // RULE_03
    else $error("read output moved with the array frozen");

  property p_din_capture;
    @(posedge i_clock) disable iff (i_rst)
      (run && !i_collar_shift_select) |=> (din_r == $past(i_wr_data));
  endproperty
  a_din_capture: assert property (p_din_capture) // RULE_02
    else $error("write data not captured on the rising edge");

  property p_addr_capture;
    @(posedge i_clock) disable iff (i_rst)
      (run && !i_collar_shift_select) |=>
      (rd_addr_r == $past(i_rd_addr) && wr_addr_r == $past(i_wr_addr));
  endproperty
  a_addr_capture: assert property (p_addr_capture) // RULE_04
    else $error("row selects not captured");

  property p_req_capture;
    @(posedge i_clock) disable iff (i_rst)
      (run && !i_collar_shift_select) |=>
      (rd_en_r == $past(i_rd_en) && wr_en_r == $past(i_wr_en));
  endproperty
  a_req_capture: assert property (p_req_capture) // RULE_05
    else $error("requests not captured");

  property p_one_cycle_read;
    @(posedge i_clock) disable iff (i_rst)
      (go && i_rd_en && !i_wr_en && !i_array_inhibit && i_rd_addr < ADDR_W'(ROWS))
      |=> (go |-> (rd_act ##1 (o_rd_data == $past(u_store.mem[rd_addr_r]))));
  endproperty
  a_one_cycle_read: assert property (p_one_cycle_read) // RULE_07
    else $error("read did not complete one cycle after capture");

  property p_scan_shift;
    @(posedge i_clock) disable iff (i_rst)
      i_collar_shift_select |=> (cap_r[0] == $past(i_scan_in));
  endproperty
  a_scan_shift: assert property (p_scan_shift) // RULE_02
    else $error("scan chain did not shift");

  property p_scan_chain;
    @(posedge i_clock) disable iff (i_rst)
      i_collar_shift_select |=> (cap_r[CHAIN_W-1:1] == $past(cap_r[CHAIN_W-2:0]));
  endproperty
  a_scan_chain: assert property (p_scan_chain) // RULE_02
    else $error("scan chain lost a bit while shifting");

  property p_range_read;
    @(posedge i_clock) disable iff (i_rst)
      (go && !inh_r && rd_en_r && rd_addr_r >= ADDR_W'(ROWS))
      |=> (o_rd_data == {WIDTH{1'b1}});
  endproperty
  a_range_read: assert property (p_range_read) // RULE_01
    else $error("row beyond the depth did not read as all ones");

  property p_capture_hold;
    @(posedge i_clock) disable iff (i_rst)
      (!run && !i_collar_shift_select) |=> $stable(cap_r);
  endproperty
  a_capture_hold: assert property (p_capture_hold) // RULE_05
    else $error("captured requests moved with the clock header off");

  property p_inhibit_capture;
    @(posedge i_clock) disable iff (i_rst)
      go |=> (inh_r == $past(i_array_inhibit));
  endproperty
  a_inhibit_capture: assert property (p_inhibit_capture) // RULE_17
    else $error("inhibit not captured with the requests");
endmodule // datapath_array_cell

// ===== dv/datapath_requester.sv
// far-side requester model driving the array request inputs
module datapath_requester (
  input  wire logic                          i_clock,
  output      logic                          o_rd_en,
  output      logic [array_pkg::ADDR_W-1:0]  o_rd_addr,
  output      logic                          o_wr_en,
  output      logic [array_pkg::ADDR_W-1:0]  o_wr_addr,
  output      logic [array_pkg::WIDTH-1:0]   o_wr_data,
  output      logic                          o_inhibit
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_rd_en   = 1'b0;
    o_rd_addr = 8'h00;
    o_wr_en   = 1'b0;
    o_wr_addr = 8'h00;
    o_wr_data = '0;
    o_inhibit = 1'b0;
  end
  // one request per edge; unused fields toggle so stale values never look valid
  task automatic issue(input logic rd, input logic [7:0] ra, input logic wr,
                       input logic [7:0] wa, input logic [array_pkg::WIDTH-1:0] d,
                       input logic inh, input logic clash_ok);
    @(posedge i_clock);
    if (rd && wr && ra == wa && !clash_ok) begin
      wr = 1'b0;
    end
    o_rd_en   <= rd;
    o_rd_addr <= rd ? ra : ~o_rd_addr;
    o_wr_en   <= wr;
    o_wr_addr <= wr ? wa : ~o_wr_addr;
    o_wr_data <= wr ? d : ~o_wr_data;
    o_inhibit <= inh;
  endtask
endmodule // datapath_requester

// ===== dv/sram_1r1w_144x149_tb_top.sv
// self-checking bench for the 144 x 149 datapath array
module sram_1r1w_144x149_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned W = array_pkg::WIDTH;
  logic         i_clock = 1'b0;
  logic         i_rst   = 1'b1;
  logic         rd_en;
  logic         wr_en;
  logic         inhibit;
  logic         enable  = 1'b1;
  logic         override = 1'b0;
  logic         shift_sel = 1'b0;
  logic         scan_bit = 1'b0;
  logic [7:0]   rd_addr;
  logic [7:0]   wr_addr;
  logic [W-1:0] wr_data;
  logic [W-1:0] rd_data;
  logic         scan_out;
  int           mismatches = 0;
  int           checks     = 0;

  always #20 i_clock = ~i_clock;

  datapath_requester u_req (
    .i_clock   (i_clock),
    .o_rd_en   (rd_en),
    .o_rd_addr (rd_addr),
    .o_wr_en   (wr_en),
    .o_wr_addr (wr_addr),
    .o_wr_data (wr_data),
    .o_inhibit (inhibit)
  );

  // header and scan pins stay quiet except in the freeze and scan scenarios
  datapath_array_cell u_dut (
    .i_clock                 (i_clock),
    .i_rst                   (i_rst),
    .i_rd_en                 (rd_en),
    .i_rd_addr               (rd_addr),
    .i_wr_en                 (wr_en),
    .i_wr_addr               (wr_addr),
    .i_wr_data               (wr_data),
    .i_array_inhibit         (inhibit),
    .i_clock_header_enable   (enable),
    .i_clock_header_override (override),
    .i_collar_shift_select   (shift_sel),
    .i_scan_in               (scan_bit),
    .o_rd_data               (rd_data),
    .o_scan_out              (scan_out)
  );

  function automatic logic [W-1:0] pat(input logic [15:0] k);
    return {k[4:0], {9{k}}};
  endfunction

  task automatic cmp(input logic [W-1:0] got, input logic [W-1:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one request, one idle edge, then the answer one cycle after capture
  task automatic step(input logic rd, input logic [7:0] ra, input logic wr,
                      input logic [7:0] wa, input logic [W-1:0] d,
                      input logic inh, input logic [W-1:0] exp);
    u_req.issue(rd, ra, wr, wa, d, inh, 1'b1);
    u_req.issue(1'b0, 8'h00, 1'b0, 8'h00, '0, 1'b0, 1'b0);
    @(posedge i_clock);
    #1;
    cmp(rd_data, exp);
  endtask

  task automatic wrap_up();
    if (mismatches == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic t_reset();
    cmp(rd_data, '1);
    cmp(W'(scan_out), '0);
  endtask

  task automatic t_write_read();
    step(1'b0, 8'h00, 1'b1, 8'h00, pat(16'h0000), 1'b0, '1);
    step(1'b0, 8'h00, 1'b1, 8'h8F, pat(16'h008F), 1'b0, '1);
    step(1'b1, 8'h00, 1'b0, 8'h00, '0, 1'b0, pat(16'h0000));
    step(1'b1, 8'h8F, 1'b0, 8'h00, '0, 1'b0, pat(16'h008F));
    step(1'b0, 8'h00, 1'b0, 8'h00, '0, 1'b0, '1);
    step(1'b1, 8'h90, 1'b0, 8'h00, '0, 1'b0, '1);
  endtask

  task automatic t_dual_port();
    step(1'b1, 8'h00, 1'b1, 8'h05, pat(16'h0005), 1'b0, pat(16'h0000));
    step(1'b1, 8'h05, 1'b0, 8'h00, '0, 1'b0, pat(16'h0005));
  endtask

  // inhibit must block both the write and the read of the same cycle
  task automatic t_inhibit();
    step(1'b0, 8'h00, 1'b1, 8'h07, pat(16'h0007), 1'b0, '1);
    step(1'b0, 8'h00, 1'b1, 8'h09, pat(16'h0009), 1'b0, '1);
    step(1'b1, 8'h07, 1'b1, 8'h09, pat(16'h0063), 1'b1, '1);
    step(1'b1, 8'h07, 1'b0, 8'h00, '0, 1'b0, pat(16'h0007));
    step(1'b1, 8'h09, 1'b0, 8'h00, '0, 1'b0, pat(16'h0009));
  endtask

  task automatic t_collision();
    step(1'b1, 8'h07, 1'b1, 8'h07, pat(16'h002A), 1'b0, pat(16'h0007));
    step(1'b1, 8'h07, 1'b0, 8'h00, '0, 1'b0, pat(16'h002A));
  endtask

  // header off holds the last answer; the override alone runs the array again
  task automatic t_freeze();
    u_req.issue(1'b1, 8'h00, 1'b0, 8'h00, '0, 1'b0, 1'b0);
    u_req.issue(1'b0, 8'h00, 1'b0, 8'h00, '0, 1'b0, 1'b0);
    @(posedge i_clock);
    enable <= 1'b0;
    @(posedge i_clock);
    override <= 1'b1;
    #1;
    cmp(rd_data, pat(16'h0000));
    step(1'b1, 8'h8F, 1'b0, 8'h00, '0, 1'b0, pat(16'h008F));
    @(posedge i_clock);
    enable   <= 1'b1;
    override <= 1'b0;
  endtask

  // back-to-back requests: each answer stands one cycle after its capture
  task automatic t_back_to_back();
    u_req.issue(1'b0, 8'h00, 1'b1, 8'h10, pat(16'h0010), 1'b0, 1'b0);
    u_req.issue(1'b1, 8'h10, 1'b0, 8'h00, '0, 1'b0, 1'b0);
    u_req.issue(1'b1, 8'h10, 1'b1, 8'h11, pat(16'h0011), 1'b0, 1'b0);
    #1;
    cmp(rd_data, '1);
    u_req.issue(1'b1, 8'h11, 1'b0, 8'h00, '0, 1'b0, 1'b0);
    #1;
    cmp(rd_data, pat(16'h0010));
    u_req.issue(1'b1, 8'h11, 1'b1, 8'h11, pat(16'h0055), 1'b0, 1'b1);
    #1;
    cmp(rd_data, pat(16'h0010));
    u_req.issue(1'b1, 8'h11, 1'b0, 8'h00, '0, 1'b0, 1'b0);
    #1;
    cmp(rd_data, pat(16'h0011));
    u_req.issue(1'b0, 8'h00, 1'b0, 8'h00, '0, 1'b0, 1'b0);
    #1;
    cmp(rd_data, pat(16'h0011));
    u_req.issue(1'b0, 8'h00, 1'b0, 8'h00, '0, 1'b0, 1'b0);
    #1;
    cmp(rd_data, pat(16'h0055));
  endtask

  // one marker bit walks the whole chain; the array stays frozen meanwhile
  task automatic t_scan();
    @(posedge i_clock);
    shift_sel <= 1'b1;
    scan_bit  <= 1'b1;
    @(posedge i_clock);
    scan_bit  <= 1'b0;
    repeat (array_pkg::CHAIN_W - 1) @(posedge i_clock);
    #1;
    cmp(W'(scan_out), W'(1'b1));
    @(posedge i_clock);
    shift_sel <= 1'b0;
    #1;
    cmp(W'(scan_out), '0);
    cmp(rd_data, '1);
  endtask

  initial begin
    repeat (3) @(posedge i_clock);
    i_rst <= 1'b0;
    #1;
    t_reset();
    t_write_read();
    t_dual_port();
    t_inhibit();
    t_collision();
    t_freeze();
    t_back_to_back();
    t_scan();
    wrap_up();
  end

  // about 233 cycles are needed; a hang is cut far beyond that
  initial begin
    #100us;
    mismatches++;
    wrap_up();
  end
endmodule // sram_1r1w_144x149_tb_top
